// File: design/tac_pkg.sv
package tac_pkg;

    // ------------------------------------------------------------
    // Result and control byte layout
    // ------------------------------------------------------------
    localparam int RES_FULL = 12;
    localparam logic [3:0] CTRL_LAST = 4'h7;
    localparam logic [3:0] ACQ_FIRST = 4'h4;
    localparam logic [3:0] CH_LAST = 4'h3;
    localparam logic [3:0] LAST_BIT_FULL = 4'hb;
    localparam logic [3:0] LAST_BIT_FAST = 4'h7;
    localparam logic [3:0] BIT_ONE = 4'h1;
    // Positions inside the seven bits that follow the start bit
    localparam int CB_CH_HI = 6;
    localparam int CB_CH_LO = 4;
    localparam int CB_MODE = 3;
    localparam int CB_REF = 2;
    localparam int CB_PD1 = 1;
    localparam int CB_PD0 = 0;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic PD0_RESET = 1'b1;
    localparam logic PD1_RESET = 1'b0;
    localparam logic MODE_RESET = 1'b0;
    localparam logic REF_RESET = 1'b1;
    localparam logic [2:0] CH_RESET = 3'h0;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [2:0] {
        TAC_IDLE = 3'b001,
        TAC_BUSY = 3'b010,
        TAC_SHIFT = 3'b100
    } tac_state_t;

endpackage : tac_pkg

// File: design/tac_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tac_link_if;
    logic cs_n_lvl;
    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic din_lvl;

    modport sync (
        output cs_n_lvl,
        output sclk_lvl,
        output sclk_rise,
        output sclk_fall,
        output din_lvl
    );
    modport core (
        input cs_n_lvl,
        input sclk_lvl,
        input sclk_rise,
        input sclk_fall,
        input din_lvl
    );
endinterface : tac_link_if
`default_nettype wire

// File: design/tac_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tac_pin_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_sel_n,
    input wire logic shift_clock,
    input wire logic serial_in,
    tac_link_if.sync link
);
    // ------------------------------------------------------------
    // Two-stage synchronisers; the third stage only feeds edge finding
    // ------------------------------------------------------------
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic sclk_prev_reg;

    // No reset: the stages track the pins through reset, so a clock
    // parked high for the strap gives no false edge on release
    always_ff @(posedge clk_sys) begin
        meta_reg <= {serial_in, shift_clock, chip_sel_n};
        sync_reg <= meta_reg;
    end

    always_ff @(posedge clk_sys) begin
        sclk_prev_reg <= sync_reg[1];
    end

    // Din and clock share the same delay, so sampling stays aligned
    assign link.cs_n_lvl = sync_reg[0];
    assign link.sclk_lvl = sync_reg[1];
    assign link.din_lvl = sync_reg[2];
    // Edges are masked while reset holds the core
    assign link.sclk_rise = ~rst & sync_reg[1] & ~sclk_prev_reg;
    assign link.sclk_fall = ~rst & ~sync_reg[1] & sclk_prev_reg;

endmodule : tac_pin_sync
`default_nettype wire

// File: design/tac_serial_conv.sv
`timescale 1ns/100ps
`default_nettype none
module tac_serial_conv (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_sel_n,
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic [tac_pkg::RES_FULL-1:0] adc_code,
    output logic serial_out,
    output logic serial_out_oe,
    output logic busy_out,
    output logic busy_oe,
    output logic [2:0] channel_select,
    output logic sample_acquire,
    output logic adc_powered,
    output logic ref_powered,
    output logic drivers_on,
    output logic bias_high
);
    import tac_pkg::*;

    tac_link_if link ();

    tac_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .chip_sel_n(chip_sel_n),
        .shift_clock(shift_clock),
        .serial_in(serial_in),
        .link(link)
    );

    logic cs_high;
    logic acquiring;
    logic converting;
    logic take_byte;
    logic [3:0] rx_cnt_reg;
    logic [5:0] rx_sh_reg;
    logic [6:0] ctrl_reg;
    logic [2:0] acq_ch_reg;
    logic byte_pend_reg;
    tac_state_t state_reg;
    logic busy_reg;
    logic out_reg;
    logic [RES_FULL-1:0] res_sh_reg;
    logic [3:0] out_cnt_reg;
    logic mode_reg;
    logic ref_mode_reg;
    logic pd0_reg;
    logic pd1_reg;
    logic [2:0] conv_ch_reg;
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic oe_reg;
    logic adc_pwr_reg;
    logic drv_reg;
    logic acq_out_reg;
    logic [2:0] ch_out_reg;

    assign cs_high = link.cs_n_lvl;
    assign converting = (state_reg != TAC_IDLE);
    assign acquiring = (rx_cnt_reg >= ACQ_FIRST) | byte_pend_reg;
    // Select must be low too, or a deselect edge could reload the settings
    assign take_byte = link.sclk_fall & byte_pend_reg & !cs_high
                       & (state_reg == TAC_IDLE);

    // ------------------------------------------------------------
    // Control byte receiver
    // ------------------------------------------------------------
    // Runs independently of the result shifter so that the next byte
    // can overlap the current result.
    always_ff @(posedge clk_sys) begin
        if (rst || cs_high) begin
            rx_cnt_reg <= 4'h0;
            rx_sh_reg <= 6'h0;
            byte_pend_reg <= 1'b0;
        end else if (link.sclk_rise) begin
            if (rx_cnt_reg == 4'h0) begin
                if (link.din_lvl) begin
                    rx_cnt_reg <= 4'h1;
                end
            end else if (rx_cnt_reg == CTRL_LAST) begin
                rx_cnt_reg <= 4'h0;
                byte_pend_reg <= 1'b1;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
                rx_sh_reg <= {rx_sh_reg[4:0], link.din_lvl};
            end
        end else if (take_byte) begin
            byte_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= 7'h0;
            acq_ch_reg <= CH_RESET;
        end else if (link.sclk_rise && !cs_high) begin
            if (rx_cnt_reg == CTRL_LAST) begin
                ctrl_reg <= {rx_sh_reg, link.din_lvl};
            end
            if (rx_cnt_reg == CH_LAST) begin
                acq_ch_reg <= {rx_sh_reg[1:0], link.din_lvl};
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion sequence and result shifter
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || cs_high) begin
            state_reg <= TAC_IDLE;
            busy_reg <= 1'b0;
            out_reg <= 1'b0;
            res_sh_reg <= '0;
            out_cnt_reg <= 4'h0;
        end else if (link.sclk_fall) begin
            case (state_reg)
                TAC_IDLE: begin
                    out_reg <= 1'b0;
                    if (byte_pend_reg) begin
                        state_reg <= TAC_BUSY;
                        busy_reg <= 1'b1;
                    end
                end
                TAC_BUSY: begin
                    // Straight binary code passes unchanged, MSB first
                    busy_reg <= 1'b0;
                    out_reg <= adc_code[RES_FULL-1];
                    res_sh_reg <= {adc_code[RES_FULL-2:0], 1'b0};
                    out_cnt_reg <= mode_reg ? LAST_BIT_FAST
                                            : LAST_BIT_FULL;
                    state_reg <= TAC_SHIFT;
                end
                TAC_SHIFT: begin
                    out_reg <= res_sh_reg[RES_FULL-1];
                    res_sh_reg <= {res_sh_reg[RES_FULL-2:0], 1'b0};
                    out_cnt_reg <= out_cnt_reg - 4'h1;
                    if (out_cnt_reg == BIT_ONE) begin
                        state_reg <= TAC_IDLE;
                    end
                end
                default: begin
                    state_reg <= TAC_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Settings taken from the control byte as busy rises
    // ------------------------------------------------------------
    // Chip select does not reset these, so the reference stays as set.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_reg <= MODE_RESET;
            ref_mode_reg <= REF_RESET;
            pd0_reg <= PD0_RESET;
            pd1_reg <= PD1_RESET;
            conv_ch_reg <= CH_RESET;
        end else if (take_byte) begin
            mode_reg <= ctrl_reg[CB_MODE];
            ref_mode_reg <= ctrl_reg[CB_REF];
            pd0_reg <= ctrl_reg[CB_PD0];
            pd1_reg <= ctrl_reg[CB_PD1];
            conv_ch_reg <= ctrl_reg[CB_CH_HI:CB_CH_LO];
        end else if (strap_cnt_reg == STRAP_WAIT && !strap_done_reg
                     && !cs_high && link.sclk_lvl) begin
            pd0_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power-up strap check
    // ------------------------------------------------------------
    // Waits out the synchroniser so the pins are seen, not reset values.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (strap_cnt_reg != STRAP_WAIT) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Power, drivers and pin enables
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oe_reg <= 1'b0;
            adc_pwr_reg <= 1'b0;
            drv_reg <= 1'b0;
            acq_out_reg <= 1'b0;
            ch_out_reg <= CH_RESET;
        end else begin
            oe_reg <= !cs_high;
            // A paused clock leaves the state alone, so power holds
            adc_pwr_reg <= !cs_high
                           && (pd0_reg || converting || acquiring);
            drv_reg <= !cs_high && (acquiring
                       || (converting && !ref_mode_reg));
            acq_out_reg <= !cs_high && acquiring;
            ch_out_reg <= acquiring ? acq_ch_reg : conv_ch_reg;
        end
    end

    assign serial_out = out_reg;
    assign serial_out_oe = oe_reg;
    assign busy_out = busy_reg;
    assign busy_oe = oe_reg;
    assign channel_select = ch_out_reg;
    assign sample_acquire = acq_out_reg;
    assign adc_powered = adc_pwr_reg;
    assign ref_powered = pd1_reg;
    assign drivers_on = drv_reg;
    assign bias_high = pd0_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_byte_done;
        link.sclk_rise && rx_cnt_reg == CTRL_LAST && !cs_high;
    endsequence
    sequence s_busy_start;
        take_byte ##1 busy_reg && state_reg == TAC_BUSY;
    endsequence

    byte_to_busy_a: assert property (
        s_byte_done |=> byte_pend_reg)
        else $error("control byte not flagged after eighth bit");
    busy_latch_a: assert property (
        s_busy_start |-> pd1_reg == $past(ctrl_reg[CB_PD1]))
        else $error("reference setting not latched with busy");
    busy_edge_a: assert property (
        $changed(busy_reg) && !$past(cs_high) |-> $past(link.sclk_fall))
        else $error("busy changed away from a falling edge");
    out_edge_a: assert property (
        $changed(out_reg) && !$past(cs_high) |-> $past(link.sclk_fall))
        else $error("serial output changed away from a falling edge");
    msb_first_a: assert property (
        $fell(busy_reg) && !$past(cs_high)
        |-> out_reg == $past(adc_code[RES_FULL-1])
            && state_reg == TAC_SHIFT)
        else $error("MSB not presented after busy");
    width_sel_a: assert property (
        $rose(state_reg == TAC_SHIFT)
        |-> out_cnt_reg == (mode_reg ? 4'h7 : 4'hb))
        else $error("result width does not follow mode");
    conv_end_a: assert property (
        state_reg == TAC_SHIFT && out_cnt_reg == 4'h1
        && link.sclk_fall && !cs_high |=> state_reg == TAC_IDLE)
        else $error("conversion did not end after bit one");
    trail_zero_a: assert property (
        state_reg == TAC_IDLE && link.sclk_fall && !cs_high |=> !out_reg)
        else $error("trailing clock gave a nonzero bit");
    cs_abort_a: assert property (
        cs_high |=> state_reg == TAC_IDLE && !busy_reg
                    && !adc_pwr_reg && !oe_reg)
        else $error("deselect did not abort and power down");
    ref_keep_a: assert property (
        cs_high |=> pd1_reg == $past(pd1_reg))
        else $error("reference changed on deselect");
    hold_power_a: assert property (
        converting && !cs_high && !link.sclk_fall [*3]
        |=> adc_pwr_reg || cs_high)
        else $error("converter unpowered during paused conversion");
    drv_single_a: assert property (
        converting && ref_mode_reg && !acquiring && !cs_high
        |=> !drv_reg)
        else $error("drivers on while converting single-ended");
    drv_diff_a: assert property (
        converting && !ref_mode_reg && !cs_high |=> drv_reg)
        else $error("drivers off while converting differential");
    start_wait_a: assert property (
        rx_cnt_reg == 4'h0 && link.sclk_rise && !link.din_lvl
        |=> rx_cnt_reg == 4'h0)
        else $error("receiver left idle without a start bit");

    // ------------------------------------------------------------
    // Checks on power, settings and the acquisition phase
    // ------------------------------------------------------------
    // The strap is looked at once, in the cycle the synchroniser settles
    sequence s_strap_seen;
        strap_cnt_reg == STRAP_WAIT && !strap_done_reg && !cs_high
        && link.sclk_lvl && !take_byte;
    endsequence

    strap_low_a: assert property (
        s_strap_seen |=> !pd0_reg)
        else $error("strap did not drop the higher-current state");
    mode_latch_a: assert property (
        take_byte |=> mode_reg == $past(ctrl_reg[CB_MODE])
                      && ref_mode_reg == $past(ctrl_reg[CB_REF]))
        else $error("mode or reference setting not taken from the byte");
    power_sel_a: assert property (
        !cs_high && !converting && !acquiring
        |=> adc_pwr_reg == $past(pd0_reg))
        else $error("idle converter power does not follow the setting");
    oe_follow_a: assert property (
        !$past(rst) |-> oe_reg == !$past(cs_high))
        else $error("output enable does not follow select");
    desel_drv_a: assert property (
        cs_high |=> !drv_reg && !acq_out_reg)
        else $error("drivers left on after deselect");
    acq_start_a: assert property (
        link.sclk_rise && rx_cnt_reg == CH_LAST && !cs_high
        |=> acquiring ##1 (acq_out_reg || $past(cs_high)))
        else $error("acquisition did not start after the channel bits");

endmodule : tac_serial_conv
`default_nettype wire

// File: sim/tac_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module tac_host_model (
    input wire logic clk_sys,
    output logic chip_sel_n,
    output logic shift_clock,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic busy_out,
    input wire logic drivers_on,
    input wire logic sample_acquire
);
    logic [0:63] acq;
    logic [0:63] dout;
    logic [0:63] bout;
    logic [0:63] drv;

    initial begin
        chip_sel_n = 1'b1;
        shift_clock = 1'b0;
        serial_in = 1'b0;
    end

    // ----------------------------------------------------------------
    // Select and clocking
    // ----------------------------------------------------------------
    // Chip select only moves with the shift clock parked low
    task automatic select(input logic cs_n);
        repeat (8) @(negedge clk_sys);
        chip_sel_n = cs_n;
        repeat (8) @(negedge clk_sys);
    endtask : select

    // Entry k holds the outputs as left by fall k-1 and rise k; capture waits for
    // the end of the high phase since the pin sync adds two cycles and the registers after it up to two more
    task automatic run(input int n, input logic [0:63] din);
        for (int k = 0; k < n; k++) begin
            serial_in = din[k];
            repeat (4) @(negedge clk_sys);
            shift_clock = 1'b1;
            repeat (4) @(negedge clk_sys);
            dout[k] = serial_out;
            bout[k] = busy_out;
            drv[k] = drivers_on;
            acq[k] = sample_acquire;
            shift_clock = 1'b0;
        end
    endtask : run

    // Power-up strap pins: select low with the clock parked high
    task automatic strap(input logic on);
        chip_sel_n = ~on;
        shift_clock = on;
    endtask : strap
endmodule : tac_host_model
`default_nettype wire

// File: sim/tac_serial_conv_test.sv
`timescale 1ns/100ps
`default_nettype none
module tac_serial_conv_test;
    import tac_pkg::*;
    logic clk_sys = 1'b0;
    logic rst;
    logic chip_sel_n;
    logic shift_clock;
    logic serial_in;
    logic [RES_FULL-1:0] adc_code;
    logic serial_out;
    logic serial_out_oe;
    logic busy_out;
    logic busy_oe;
    logic [2:0] channel_select;
    logic sample_acquire;
    logic adc_powered;
    logic ref_powered;
    logic drivers_on;
    logic bias_high;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    always #4 clk_sys = ~clk_sys;

    tac_serial_conv dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .chip_sel_n(chip_sel_n),
        .shift_clock(shift_clock),
        .serial_in(serial_in),
        .adc_code(adc_code),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .busy_out(busy_out),
        .busy_oe(busy_oe),
        .channel_select(channel_select),
        .sample_acquire(sample_acquire),
        .adc_powered(adc_powered),
        .ref_powered(ref_powered),
        .drivers_on(drivers_on),
        .bias_high(bias_high)
    );

    tac_host_model host (
        .clk_sys(clk_sys),
        .chip_sel_n(chip_sel_n),
        .shift_clock(shift_clock),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .busy_out(busy_out),
        .drivers_on(drivers_on),
        .sample_acquire(sample_acquire)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        @(negedge clk_sys);
        check(bias_high, 1'b1);
        check(serial_out_oe, 1'b0);
        check(busy_oe, 1'b0);
    endtask : t_reset

    // Two 12-bit single-ended conversions overlapped at 16 clocks each
    task automatic t_b2b12();
        @(negedge clk_sys);
        adc_code = 12'ha5c;
        host.select(1'b0);
        check(serial_out_oe, 1'b1);
        host.run(48, {8'hd6, 8'h00, 8'hd6, 40'h0});
        check(host.bout[8], 1'b1);
        check(host.bout[9], 1'b0);
        check(host.dout[9+:12], 12'ha5c);
        check(host.dout[21+:3], 12'h0);
        check(host.bout[24], 1'b1);
        check(host.dout[25+:12], 12'ha5c);
        check(host.drv[7], 1'b1);
        check(host.drv[12], 1'b0);
        check(host.acq[5], 1'b1);
        check(host.acq[9], 1'b0);
        check(adc_powered, 1'b0);
        check(ref_powered, 1'b1);
        check(bias_high, 1'b0);
        check(channel_select, 3'h5);
        host.select(1'b1);
        check(ref_powered, 1'b1);
        check(serial_out_oe, 1'b0);
        check(busy_oe, 1'b0);
    endtask : t_b2b12

    // 8-bit differential conversions framed at 15 clocks, converter powered, reference off
    task automatic t_fast8();
        @(negedge clk_sys);
        adc_code = 12'h3c7;
        host.select(1'b0);
        host.run(40, {8'ha9, 7'h0, 8'ha9, 41'h0});
        check(host.bout[8], 1'b1);
        check(host.dout[9+:8], 8'h3c);
        check(host.dout[17+:6], 6'h0);
        check(host.bout[23], 1'b1);
        check(host.dout[24+:8], 8'h3c);
        check(host.drv[12], 1'b1);
        check(adc_powered, 1'b1);
        check(bias_high, 1'b1);
        check(ref_powered, 1'b0);
        host.select(1'b1);
    endtask : t_fast8

    // Shift clock paused in mid-conversion
    task automatic t_pause();
        logic [2:0] hi;
        @(negedge clk_sys);
        adc_code = 12'h801;
        host.select(1'b0);
        host.run(12, {8'h84, 56'h0});
        hi = host.dout[9+:3];
        repeat (40) @(negedge clk_sys);
        check(adc_powered, 1'b1);
        host.run(12, 64'h0);
        check({hi, host.dout[0+:9]}, 12'h801);
        check(adc_powered, 1'b0);
        host.select(1'b1);
    endtask : t_pause

    // Abort while busy, then a fresh frame behind leading zeros
    task automatic t_abort();
        @(negedge clk_sys);
        adc_code = 12'hfff;
        host.select(1'b0);
        host.run(8, {8'h84, 56'h0});
        repeat (6) @(negedge clk_sys);
        check(busy_out, 1'b1);
        host.select(1'b1);
        check(busy_out, 1'b0);
        check(adc_powered, 1'b0);
        check(serial_out_oe, 1'b0);
        adc_code = 12'h123;
        host.select(1'b0);
        host.run(32, {3'h0, 8'h84, 53'h0});
        check(host.bout[11], 1'b1);
        check(host.dout[12+:12], 12'h123);
        host.select(1'b1);
    endtask : t_abort

    // Reset again with select low and the clock high: bias drops
    task automatic t_strap();
        @(negedge clk_sys);
        host.strap(1'b1);
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        check(bias_high, 1'b1);
        repeat (8) @(negedge clk_sys);
        check(bias_high, 1'b0);
        check(adc_powered, 1'b0);
        host.strap(1'b0);
        repeat (8) @(negedge clk_sys);
    endtask : t_strap

    initial begin
        rst = 1'b1;
        adc_code = 12'h0;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_b2b12();
        t_fast8();
        t_pause();
        t_abort();
        t_strap();
        give_verdict();
    end
endmodule : tac_serial_conv_test
`default_nettype wire
